//--- rtl/ram_port_ctrl.sv
// Port control of a synchronous dual-port RAM: input registers, counter, write pulse and output drive.
`timescale 1ns/1ns
module ram_port_ctrl (
    input  wire logic                 CLOCK,
    input  wire logic                 ARST_N,
    input  wire ram_port_pkg::ctrl_s  CTRL,
    input  wire ram_port_pkg::addr_t  ADDRESS,
    input  wire ram_port_pkg::data_t  DQ_IN,
    output ram_port_pkg::data_t       DQ_OUT,
    output logic                      DQ_OE,
    input  wire logic                 OUTPUT_ENABLE_N,
    input  wire logic                 LATENCY_SELECT,
    output ram_port_pkg::addr_t       ARRAY_ADDR,
    output logic                      ARRAY_WR_STROBE,
    output ram_port_pkg::data_t       ARRAY_WR_DATA,
    input  wire ram_port_pkg::data_t  ARRAY_RD_DATA,
    output logic                      POWER_DOWN
);
    import ram_port_pkg::*;

    logic  selected;
    logic  sel_q;
    logic  write_q;
    logic  read_q;
    logic  read_pipe_q;
    data_t wr_data_q;
    data_t rd_pipe_q;
    logic  drive_active;

    // Both chip enables must be active for the port to be selected.
    assign selected = !CTRL.select_low_active_n && CTRL.select_high_active;

    port_addr_counter counter_i (
        .CLOCK    (CLOCK),
        .ARST_N   (ARST_N),
        .CLEAR    (!CTRL.count_clear_n),
        .LOAD     (!CTRL.address_load_strobe_n),
        .ADVANCE  (!CTRL.count_advance_n),
        .EXT_ADDR (ADDRESS),
        .ADDR     (ARRAY_ADDR)
    );
    // The counter register already holds the loaded address after a load edge.

    // Chip select register also drives the standby indication.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_q <= 1'b0;
        end else begin
            sel_q <= selected;
        end
    end

    assign POWER_DOWN = !sel_q;

    // Write data and write cycle registers; the strobe lasts exactly one clock per write.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            write_q   <= 1'b0;
            wr_data_q <= DATA_RESET;
        end else begin
            write_q   <= selected && !CTRL.read_write_n;
            wr_data_q <= DQ_IN;
        end
    end

    assign ARRAY_WR_STROBE = write_q;
    assign ARRAY_WR_DATA   = wr_data_q;

    // Read activity is tracked one and two edges back for the two output latencies.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            read_q      <= 1'b0;
            read_pipe_q <= 1'b0;
        end else begin
            read_q      <= selected && CTRL.read_write_n;
            read_pipe_q <= read_q;
        end
    end

    // Extra output register used only in pipelined mode.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rd_pipe_q <= DATA_RESET;
        end else begin
            rd_pipe_q <= ARRAY_RD_DATA;
        end
    end

    // Pipelined mode also needs the select registered at the last edge, so a deselect floats at once
    // while reselecting needs two selected cycles before the drivers return.
    always_comb begin
        if (LATENCY_SELECT) begin
            drive_active = read_pipe_q && sel_q;
        end else begin
            drive_active = read_q;
        end
    end

    // Flow-through data comes straight from the array read path to keep its latency.
    assign DQ_OUT = LATENCY_SELECT ? rd_pipe_q : ARRAY_RD_DATA;
    assign DQ_OE  = drive_active && !OUTPUT_ENABLE_N;

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    a_clear_to_zero: assert property (!CTRL.count_clear_n |=> ARRAY_ADDR == ADDR_ZERO)
        else $error("Counter clear did not give address zero.");
    a_load_ext_addr: assert property (CTRL.count_clear_n && !CTRL.address_load_strobe_n
        |=> ARRAY_ADDR == $past(ADDRESS))
        else $error("Load strobe did not capture the external address.");
    a_hold_addr: assert property (CTRL.count_clear_n && CTRL.address_load_strobe_n
        && CTRL.count_advance_n |=> $stable(ARRAY_ADDR))
        else $error("Address changed with no load or advance.");
    a_advance_addr: assert property (CTRL.count_clear_n && CTRL.address_load_strobe_n
        && !CTRL.count_advance_n |=> ARRAY_ADDR == addr_t'($past(ARRAY_ADDR) + ADDR_STEP))
        else $error("Advance did not increment the address by one.");
    a_write_pulse: assert property (selected && !CTRL.read_write_n
        |=> ARRAY_WR_STROBE && ARRAY_WR_DATA == $past(DQ_IN) ##1 !ARRAY_WR_STROBE || $past(selected && !CTRL.read_write_n))
        else $error("Write strobe or write data wrong.");
    a_no_write: assert property (!(selected && !CTRL.read_write_n) |=> !ARRAY_WR_STROBE)
        else $error("Write strobe without a write cycle.");
    a_deselect_float: assert property (!selected |=> !DQ_OE && POWER_DOWN)
        else $error("Outputs driven or port awake after deselect.");
    a_pipe_reactivate: assert property (LATENCY_SELECT && !selected ##1
        (LATENCY_SELECT && selected && CTRL.read_write_n) |=> !DQ_OE)
        else $error("Pipelined outputs came back after one selected cycle.");
    a_oe_async: assert property (OUTPUT_ENABLE_N |-> !DQ_OE)
        else $error("Data driven while output enable is high.");
    a_flow_drive: assert property (!LATENCY_SELECT && !OUTPUT_ENABLE_N
        |-> DQ_OE == $past(selected && CTRL.read_write_n))
        else $error("Flow-through drive does not follow previous controls.");
    a_pipe_data: assert property (LATENCY_SELECT && DQ_OE |-> DQ_OUT == $past(ARRAY_RD_DATA))
        else $error("Pipelined data not delayed by one register.");

    // The checks below pin down priorities and latencies that a burst controller relies on.
    // All but a_flow_data look one or two edges back, so the first edges after reset see deselected controls.
    a_load_over_adv: assert property (CTRL.count_clear_n && !CTRL.address_load_strobe_n
        && !CTRL.count_advance_n |=> ARRAY_ADDR == $past(ADDRESS))
        else $error("Advance was not overridden by a load.");

    a_power_wake: assert property (selected |=> !POWER_DOWN)
        else $error("Port stayed in standby after a selected edge.");

    a_write_data: assert property (selected && !CTRL.read_write_n
        |=> ARRAY_WR_DATA == $past(DQ_IN))
        else $error("Write data register did not load on the edge.");

    a_clear_write: assert property (!CTRL.count_clear_n && selected && !CTRL.read_write_n
        |=> ARRAY_WR_STROBE && ARRAY_ADDR == ADDR_ZERO)
        else $error("Write coincident with clear did not go to address zero.");

    a_write_next: assert property (selected && !CTRL.read_write_n && CTRL.count_clear_n
        && CTRL.address_load_strobe_n && !CTRL.count_advance_n
        |=> ARRAY_WR_STROBE && ARRAY_ADDR == addr_t'($past(ARRAY_ADDR) + ADDR_STEP))
        else $error("Advancing write did not target the next address.");

    a_pipe_drive: assert property (LATENCY_SELECT && !OUTPUT_ENABLE_N
        |-> DQ_OE == ($past(selected && CTRL.read_write_n, 2) && $past(selected)))
        else $error("Pipelined drive does not follow the two previous edges.");

    a_flow_data: assert property (!LATENCY_SELECT |-> DQ_OUT == ARRAY_RD_DATA)
        else $error("Flow-through data is not the array read data.");

    a_pipe_state: assert property (LATENCY_SELECT && !$past(selected) |-> !DQ_OE)
        else $error("Pipelined drive ignored the previous deselect.");

    a_wr_deselect: assert property (!selected |=> !ARRAY_WR_STROBE)
        else $error("Write strobe raised by a deselected port.");

    a_sel_register: assert property (POWER_DOWN == !$past(selected))
        else $error("Standby does not follow the select sampled at the last edge.");

    c_flow_read: cover property (!LATENCY_SELECT && selected && CTRL.read_write_n ##1 DQ_OE);
    c_pipe_read: cover property (LATENCY_SELECT && selected && CTRL.read_write_n ##2 DQ_OE);
    c_clear_write: cover property (!CTRL.count_clear_n && selected && !CTRL.read_write_n ##1 ARRAY_WR_STROBE);
    c_burst_advance: cover property (!CTRL.count_advance_n && CTRL.address_load_strobe_n [*3]);
    c_pipe_reselect: cover property (LATENCY_SELECT && !selected ##1 selected [*2] ##1 DQ_OE);
endmodule

//--- shared/ram_port_pkg.sv
// Shared widths, reset values and control bundle for one synchronous RAM port.
package ram_port_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 9;

    typedef logic [ADDR_W-1:0] addr_t;
    typedef logic [DATA_W-1:0] data_t;

    localparam addr_t ADDR_ZERO  = 17'h00000;
    localparam addr_t ADDR_STEP  = 17'h00001;
    localparam data_t DATA_RESET = 9'h000;

    // Port control pins, all sampled on the rising clock edge.
    typedef struct packed {
        logic select_low_active_n;
        logic select_high_active;
        logic read_write_n;
        logic address_load_strobe_n;
        logic count_advance_n;
        logic count_clear_n;
    } ctrl_s;
endpackage

//--- rtl/port_addr_counter.sv
// Internal address register of one port with clear, load and advance.
`timescale 1ns/1ns
module port_addr_counter (
    input  wire logic                 CLOCK,
    input  wire logic                 ARST_N,
    input  wire logic                 CLEAR,
    input  wire logic                 LOAD,
    input  wire logic                 ADVANCE,
    input  wire ram_port_pkg::addr_t  EXT_ADDR,
    output ram_port_pkg::addr_t       ADDR
);
    import ram_port_pkg::*;

    addr_t addr_q;

    // Clear beats load, load beats advance; no change holds the address.
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            addr_q <= ADDR_ZERO;
        end else if (CLEAR) begin
            addr_q <= ADDR_ZERO;
        end else if (LOAD) begin
            addr_q <= EXT_ADDR;
        end else if (ADVANCE) begin
            addr_q <= addr_q + ADDR_STEP;
        end
    end

    assign ADDR = addr_q;
endmodule

//--- testbench/ram_array_model.sv
// Behavioural storage array that answers the port controller's array side.
`timescale 1ns/1ns
module ram_array_model
    import ram_port_pkg::*;
(
    input  wire logic  CLOCK,
    input  wire addr_t ADDR,
    input  wire logic  WR_STROBE,
    input  wire data_t WR_DATA,
    output data_t      RD_DATA
);
    import ram_port_pkg::*;
    // Only the low address byte is decoded; the scenarios write and check read data only below 256 to keep the model small.
    data_t mem [256];

    initial begin
        foreach (mem[i]) mem[i] = data_t'(i);
    end

    always @(posedge CLOCK) begin
        if (WR_STROBE === 1'b1) mem[ADDR[7:0]] <= WR_DATA;
    end

    assign RD_DATA = mem[ADDR[7:0]];
endmodule

//--- testbench/dual_port_ram_port_counter_tb.sv
// Self-checking bench for one synchronous RAM port: counter, writes, reads and output drive.
`timescale 1ns/1ns
module dual_port_ram_port_counter_tb;
    import ram_port_pkg::*;
    logic  clk, arst_n, oe_n, lat, dq_oe, wr_str, pdown;
    ctrl_s ctrl;
    addr_t address, arr_addr;
    data_t dq_in, dq_out, wr_data, rd_data;
    int    n_mismatch, comparisons, cycles;

    ram_port_ctrl u_ram_port_ctrl (.CLOCK(clk), .ARST_N(arst_n), .CTRL(ctrl), .ADDRESS(address),
        .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .OUTPUT_ENABLE_N(oe_n), .LATENCY_SELECT(lat),
        .ARRAY_ADDR(arr_addr), .ARRAY_WR_STROBE(wr_str), .ARRAY_WR_DATA(wr_data),
        .ARRAY_RD_DATA(rd_data), .POWER_DOWN(pdown));
    ram_array_model u_ram_array_model (.CLOCK(clk), .ADDR(arr_addr), .WR_STROBE(wr_str),
        .WR_DATA(wr_data), .RD_DATA(rd_data));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs well under a hundred cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            n_mismatch = n_mismatch + 1;
            give_verdict();
        end
    end

    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Controls: lo_n, hi, read, load_n, advance_n, clear_n; applied one edge, looked at after it.
    task automatic step(input logic [5:0] c, input addr_t a, input data_t d);
        ctrl = ctrl_s'(c);
        address = a;
        dq_in = d;
        @(posedge clk);
        #1;
    endtask

    task automatic counter_ops();
        step(6'h1b, 17'h00123, 9'h000); check("load", arr_addr, 17'h00123);
        step(6'h1d, 17'h00077, 9'h000); check("advance", arr_addr, 17'h00124);
        step(6'h1f, 17'h00077, 9'h000); check("hold", arr_addr, 17'h00124);
        step(6'h18, 17'h00050, 9'h000); check("clear first", arr_addr, 17'h00000);
        step(6'h19, 17'h00050, 9'h000); check("load first", arr_addr, 17'h00050);
    endtask

    task automatic write_ops();
        step(6'h13, 17'h00005, 9'h0a5); check("wr addr", arr_addr, 17'h00005);
        step(6'h15, 17'h00077, 9'h15a); check("wr adv addr", arr_addr, 17'h00006);
        check("wr strobe", 17'(wr_str), 17'h00001);
        check("wr data", 17'(wr_data), 17'h0015a);
        step(6'h16, 17'h00077, 9'h0c3); check("wr clr addr", arr_addr, 17'h00000);
        check("wr clr data", 17'(wr_data), 17'h000c3);
        step(6'h33, 17'h00009, 9'h1ee); check("desel strobe", 17'(wr_str), 17'h00000);
        check("power down", 17'(pdown), 17'h00001);
    endtask

    task automatic read_ops();
        lat = 1'b0;
        step(6'h1b, 17'h00006, 9'h000); check("flow oe", 17'(dq_oe), 17'h00001);
        check("flow data", 17'(dq_out), 17'h0015a);
        oe_n = 1'b1;
        #1 check("async off", 17'(dq_oe), 17'h00000);
        oe_n = 1'b0;
        #1 check("async on", 17'(dq_oe), 17'h00001);
        // Deselect through the active-high enable, as a bank decode would, already in pipelined mode.
        lat = 1'b1;
        step(6'h0b, 17'h00006, 9'h000); check("desel float", 17'(dq_oe), 17'h00000);
        step(6'h1b, 17'h00000, 9'h000); check("pipe first", 17'(dq_oe), 17'h00000);
        step(6'h1b, 17'h00000, 9'h000); check("pipe second", 17'(dq_oe), 17'h00001);
        check("pipe data", 17'(dq_out), 17'h000c3);
        step(6'h1f, 17'h00077, 9'h000); check("pipe hold", 17'(dq_out), 17'h000c3);
    endtask

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        cycles = 0;
        arst_n = 1'b0;
        oe_n = 1'b0;
        lat = 1'b0;
        ctrl = ctrl_s'(6'h37);
        address = ADDR_ZERO;
        dq_in = DATA_RESET;
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        counter_ops();
        write_ops();
        read_ops();
        give_verdict();
    end
endmodule
